// file: core/rss_pkg.sv
package rss_pkg;

  // ==========================================================================
  // Operation codes from the sequencer
  // ==========================================================================
  typedef enum logic [4:0] {
    OP_NONE                 = 5'h00,
    OP_ROTATE_LEFT          = 5'h01,
    OP_ROTATE_LEFT_TO_ACC   = 5'h02,
    OP_ROTATE_LEFT_THROUGH_CARRY        = 5'h03,
    OP_ROTATE_LEFT_THROUGH_CARRY_TO_ACC = 5'h04,
    OP_ROTATE_RIGHT         = 5'h05,
    OP_ROTATE_RIGHT_TO_ACC  = 5'h06,
    OP_ROTATE_RIGHT_THROUGH_CARRY        = 5'h07,
    OP_ROTATE_RIGHT_THROUGH_CARRY_TO_ACC = 5'h08,
    OP_SUBTRACT             = 5'h09,
    OP_SUBTRACT_IMM         = 5'h0a,
    OP_SUBTRACT_TO_MEM      = 5'h0b,
    OP_SUBTRACT_WITH_BORROW = 5'h0c,
    OP_SUBTRACT_WITH_BORROW_TO_MEM = 5'h0d,
    OP_DECREMENT_SKIP_ZERO  = 5'h0e,
    OP_DECREMENT_SKIP_ZERO_TO_ACC = 5'h0f,
    OP_INCREMENT_SKIP_ZERO  = 5'h10,
    OP_INCREMENT_SKIP_ZERO_TO_ACC = 5'h11,
    OP_SKIP_BIT_NONZERO     = 5'h12,
    OP_SKIP_IF_ZERO         = 5'h13,
    OP_SKIP_IF_ZERO_MOVE_ACC = 5'h14,
    OP_SET_BYTE             = 5'h15,
    OP_SET_BIT              = 5'h16,
    OP_NIBBLE_EXCHANGE      = 5'h17,
    OP_NIBBLE_EXCHANGE_TO_ACC = 5'h18
  } rss_op_t;

  localparam int          DATA_W      = 8;
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [7:0]  BYTE_ONES   = 8'hff;
  localparam logic [7:0]  BYTE_ONE    = 8'h01;
  localparam logic [3:0]  FLAGS_RESET = 4'h0;
  localparam int          SKIP_DUMMY_CYCLES = 1;

  // One decoded instruction from the sequencer
  typedef struct packed {
    rss_op_t    op;
    logic [2:0] bit_sel;
    logic [7:0] imm;
  } rss_cmd_t;

  // Arithmetic flags
  typedef struct packed {
    logic overflow_flag;
    logic zero;
    logic half_carry_flag;
    logic carry;
  } rss_flags_t;

  // Memory write request
  typedef struct packed {
    logic       we;
    logic [7:0] data;
  } rss_mem_wr_t;

endpackage

// file: core/rss_subtractor.sv
`timescale 1ns/1ns
module rss_subtractor
  import rss_pkg::*;
(
  input  wire logic [7:0] minuend_i,    // Accumulator value
  input  wire logic [7:0] subtrahend_i, // Memory or literal operand
  input  wire logic       borrow_i,     // Inverted carry, or zero
  output logic [7:0]      diff_o,       // Eight-bit difference
  output rss_flags_t      flags_o       // Resulting flags
);

  logic [8:0] full;
  logic [4:0] low;

  // ==========================================================================
  // Difference and flags
  // ==========================================================================
  always_comb
  begin
    full   = {1'b0, minuend_i} - {1'b0, subtrahend_i} - {8'h00, borrow_i};
    low    = {1'b0, minuend_i[3:0]} - {1'b0, subtrahend_i[3:0]} - {4'h0, borrow_i};
    diff_o = full[7:0];
    flags_o.carry           = ~full[8];
    flags_o.half_carry_flag = ~low[4];
    flags_o.zero            = (full[7:0] == 8'h00);
    flags_o.overflow_flag   = (minuend_i[7] ^ subtrahend_i[7])
                              & (minuend_i[7] ^ full[7]);
  end

endmodule // rss_subtractor

// file: core/rss_rotator.sv
`timescale 1ns/1ns
module rss_rotator
  import rss_pkg::*;
(
  input  wire logic [7:0] data_i,   // Byte to rotate
  input  wire logic       carry_i,  // Current carry
  input  wire logic       right_i,  // Rotate right when high
  input  wire logic       thru_i,   // Rotate through carry
  output logic [7:0]      data_o,   // Rotated byte
  output logic            carry_o   // Bit shifted out
);

  // ==========================================================================
  // Rotation
  // ==========================================================================
  always_comb
  begin
    if (right_i)
    begin
      data_o  = {thru_i ? carry_i : data_i[0], data_i[7:1]};
      carry_o = data_i[0];
    end
    else
    begin
      data_o  = {data_i[6:0], thru_i ? carry_i : data_i[7]};
      carry_o = data_i[7];
    end
  end

endmodule // rss_rotator

// file: core/rss_datapath.sv
`timescale 1ns/1ns
// Function
// - Rotate left to acc, top into bottom.
// - Rotate left through carry, carry only.
// - Rotate right, bottom into top, no flags.
// - Rotate right through carry, carry only.
// - Acc-destination rotates leave memory unchanged.
// - Subtract with borrow: acc-mem-not carry.
// - Carry set when subtraction not negative.
// - All subtractions update four arithmetic flags.
// - Immediate subtract result into accumulator.
// - Subtract to memory keeps accumulator.
// - Decrement memory, skip when zero.
// - Decrement into acc, skip when zero.
// - Increment, skip when result wraps zero.
// - Taken skip adds one dummy cycle.
// - Skip when selected bit is one.
// - Skip when memory byte is zero.
// - Set byte writes all ones.
// - Set bit forces selected bit high.
// - Nibble swap written back to memory.
// - Nibble swap to acc keeps memory.
// - Copy byte to acc, skip if zero.
module rss_datapath
  import rss_pkg::*;
(
  input  wire logic        clk_sys_i,     // Core clock
  input  wire logic        rst_i,         // Asynchronous reset, active high
  input  wire logic        cmd_valid_i,   // Decoded instruction present
  input  wire rss_cmd_t    cmd_i,         // Decoded instruction
  input  wire logic [7:0]  mem_rdata_i,   // Addressed memory byte
  output logic             cmd_ready_o,   // Ready for next instruction
  output rss_mem_wr_t      mem_wr_o,      // Memory write strobe and data
  output logic [7:0]       acc_o,         // Accumulator
  output rss_flags_t       flags_o,       // Arithmetic flags
  output logic             skip_o,        // Next instruction discarded
  output logic             dummy_o        // Dummy cycle in progress
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_DUMMY = 2'b10
  } rss_state_t;

  // Gap length minus one; zero gives a single dummy cycle
  localparam logic [1:0] DUMMY_LOAD = 2'(SKIP_DUMMY_CYCLES - 1);

  rss_state_t  state;
  rss_state_t  next_state;
  logic [7:0]  acc;
  rss_flags_t  flags;
  logic        take;

  logic [7:0]  rot_data;
  logic        rot_carry;
  logic        rot_right;
  logic        rot_thru;
  logic [7:0]  sub_b;
  logic        sub_borrow;
  logic [7:0]  sub_diff;
  rss_flags_t  sub_flags;

  logic [7:0]  next_acc;
  rss_flags_t  next_flags;
  logic        next_we;
  logic [7:0]  next_wdata;
  logic        next_skip;
  logic [7:0]  dec_val;
  logic [7:0]  inc_val;
  logic [7:0]  bit_mask;
  logic        skip_taken;
  logic [1:0]  dummy_left;
  logic [1:0]  next_dummy_left;

  assign take = cmd_valid_i && (state == ST_RUN);
  // A word offered in the dummy cycle is never taken, so skips cannot chain
  assign skip_taken = take && next_skip;

  // ==========================================================================
  // Shared units
  // ==========================================================================
  always_comb
  begin
    rot_right = 1'b0;
    rot_thru  = 1'b0;
    case (cmd_i.op)
      OP_ROTATE_LEFT_THROUGH_CARRY,
      OP_ROTATE_LEFT_THROUGH_CARRY_TO_ACC:
        rot_thru = 1'b1;
      OP_ROTATE_RIGHT,
      OP_ROTATE_RIGHT_TO_ACC:
        rot_right = 1'b1;
      OP_ROTATE_RIGHT_THROUGH_CARRY,
      OP_ROTATE_RIGHT_THROUGH_CARRY_TO_ACC:
      begin
        rot_right = 1'b1;
        rot_thru  = 1'b1;
      end
      default:
      begin
        rot_right = 1'b0;
        rot_thru  = 1'b0;
      end
    endcase
  end

  rss_rotator u_rotator (
    .data_i  (mem_rdata_i),
    .carry_i (flags.carry),
    .right_i (rot_right),
    .thru_i  (rot_thru),
    .data_o  (rot_data),
    .carry_o (rot_carry)
  );

  // Literal replaces memory operand for the immediate form
  assign sub_b = (cmd_i.op == OP_SUBTRACT_IMM) ? cmd_i.imm : mem_rdata_i;
  // Borrow is the complement of carry for the borrow forms only
  assign sub_borrow = ((cmd_i.op == OP_SUBTRACT_WITH_BORROW)
                      || (cmd_i.op == OP_SUBTRACT_WITH_BORROW_TO_MEM))
                      ? ~flags.carry : 1'b0;

  rss_subtractor u_subtractor (
    .minuend_i    (acc),
    .subtrahend_i (sub_b),
    .borrow_i     (sub_borrow),
    .diff_o       (sub_diff),
    .flags_o      (sub_flags)
  );

  // Wrap at zero and ff is intended; the skip tests the value written
  assign dec_val  = mem_rdata_i - BYTE_ONE;
  assign inc_val  = mem_rdata_i + BYTE_ONE;
  assign bit_mask = BYTE_ONE << cmd_i.bit_sel;

  // ==========================================================================
  // Execute decode
  // ==========================================================================
  always_comb
  begin
    next_acc   = acc;
    next_flags = flags;
    next_we    = 1'b0;
    next_wdata = mem_rdata_i;
    next_skip  = 1'b0;
    case (cmd_i.op)
      OP_ROTATE_LEFT,
      OP_ROTATE_RIGHT:
      begin
        next_we    = 1'b1;
        next_wdata = rot_data;
      end
      OP_ROTATE_LEFT_TO_ACC,
      OP_ROTATE_RIGHT_TO_ACC:
        next_acc = rot_data;
      OP_ROTATE_LEFT_THROUGH_CARRY,
      OP_ROTATE_RIGHT_THROUGH_CARRY:
      begin
        next_we          = 1'b1;
        next_wdata       = rot_data;
        next_flags.carry = rot_carry;
      end
      OP_ROTATE_LEFT_THROUGH_CARRY_TO_ACC,
      OP_ROTATE_RIGHT_THROUGH_CARRY_TO_ACC:
      begin
        next_acc         = rot_data;
        next_flags.carry = rot_carry;
      end
      OP_SUBTRACT,
      OP_SUBTRACT_IMM,
      OP_SUBTRACT_WITH_BORROW:
      begin
        next_acc   = sub_diff;
        next_flags = sub_flags;
      end
      OP_SUBTRACT_TO_MEM,
      OP_SUBTRACT_WITH_BORROW_TO_MEM:
      begin
        next_we    = 1'b1;
        next_wdata = sub_diff;
        next_flags = sub_flags;
      end
      OP_DECREMENT_SKIP_ZERO:
      begin
        next_we    = 1'b1;
        next_wdata = dec_val;
        next_skip  = (dec_val == 8'h00);
      end
      OP_DECREMENT_SKIP_ZERO_TO_ACC:
      begin
        next_acc  = dec_val;
        next_skip = (dec_val == 8'h00);
      end
      OP_INCREMENT_SKIP_ZERO:
      begin
        next_we    = 1'b1;
        next_wdata = inc_val;
        next_skip  = (inc_val == 8'h00);
      end
      OP_INCREMENT_SKIP_ZERO_TO_ACC:
      begin
        next_acc  = inc_val;
        next_skip = (inc_val == 8'h00);
      end
      OP_SKIP_BIT_NONZERO:
        next_skip = mem_rdata_i[cmd_i.bit_sel];
      OP_SKIP_IF_ZERO:
        next_skip = (mem_rdata_i == 8'h00);
      OP_SKIP_IF_ZERO_MOVE_ACC:
      begin
        next_acc  = mem_rdata_i;
        next_skip = (mem_rdata_i == 8'h00);
      end
      OP_SET_BYTE:
      begin
        next_we    = 1'b1;
        next_wdata = BYTE_ONES;
      end
      OP_SET_BIT:
      begin
        next_we    = 1'b1;
        next_wdata = mem_rdata_i | bit_mask;
      end
      OP_NIBBLE_EXCHANGE:
      begin
        next_we    = 1'b1;
        next_wdata = {mem_rdata_i[3:0], mem_rdata_i[7:4]};
      end
      OP_NIBBLE_EXCHANGE_TO_ACC:
        next_acc = {mem_rdata_i[3:0], mem_rdata_i[7:4]};
      default:
      begin
        next_acc   = acc;
        next_flags = flags;
      end
    endcase
  end

  // ==========================================================================
  // Sequencing
  // ==========================================================================
  always_comb
  begin
    next_state      = state;
    next_dummy_left = dummy_left;
    case (state)
      ST_RUN:
      begin
        if (skip_taken)
        begin
          next_state      = ST_DUMMY;
          next_dummy_left = DUMMY_LOAD;
        end
      end
      ST_DUMMY:
      begin
        if (dummy_left == 2'h0)
          next_state = ST_RUN;
        else
          next_dummy_left = dummy_left - 2'h1;
      end
      default:
      begin
        next_state      = ST_RUN;
        next_dummy_left = 2'h0;
      end
    endcase
  end

  // State and gap count reset together so ready is high after reset
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      dummy_left <= 2'h0;
    else
      dummy_left <= next_dummy_left;
  end

  // Ready drops for the dummy cycle so the sequencer holds its next word
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmd_ready_o <= 1'b1;
      dummy_o     <= 1'b0;
      skip_o      <= 1'b0;
    end
    else
    begin
      cmd_ready_o <= (next_state == ST_RUN);
      dummy_o     <= (next_state == ST_DUMMY);
      skip_o      <= skip_taken;
    end
  end

  // ==========================================================================
  // Architectural state
  // ==========================================================================
  // Acc and flags hold between instructions; only a taken word moves them
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc   <= ACC_RESET;
      flags <= FLAGS_RESET;
    end
    else if (take)
    begin
      acc   <= next_acc;
      flags <= next_flags;
    end
  end

  // Data follows decode every cycle; only the strobe marks a real write
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      mem_wr_o <= '0;
    else
    begin
      mem_wr_o.we   <= take && next_we;
      mem_wr_o.data <= next_wdata;
    end
  end

  // Outputs are the architectural registers themselves
  assign acc_o   = acc;
  assign flags_o = flags;

endmodule // rss_datapath

// file: tb/rss_datapath_properties.sv
`timescale 1ns/1ns
module rss_datapath_properties
  import rss_pkg::*;
(
  input wire logic        clk_sys_i,   // Core clock
  input wire logic        rst_i,       // Reset, active high
  input wire logic        cmd_valid_i, // Instruction present
  input wire rss_cmd_t    cmd_i,       // Instruction
  input wire logic [7:0]  mem_rdata_i, // Memory byte
  input wire logic        cmd_ready_o, // Ready
  input wire rss_mem_wr_t mem_wr_o,    // Memory write
  input wire logic [7:0]  acc_o,       // Accumulator
  input wire rss_flags_t  flags_o,     // Flags
  input wire logic        skip_o,      // Skip pulse
  input wire logic        dummy_o      // Dummy pulse
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic tk;
  assign tk = cmd_valid_i && cmd_ready_o;
  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_skip_dummy: assert property (skip_o |-> dummy_o && !cmd_ready_o ##1
    cmd_ready_o && !dummy_o && !skip_o) else $error("skip not followed by one dummy");
  a_set_byte: assert property (tk && cmd_i.op == OP_SET_BYTE |=> mem_wr_o.we &&
    mem_wr_o.data == 8'hff && $stable(flags_o)) else $error("set byte wrong");
  a_set_bit: assert property (tk && cmd_i.op == OP_SET_BIT |=> mem_wr_o.we &&
    mem_wr_o.data == ($past(mem_rdata_i) | (8'h01 << $past(cmd_i.bit_sel))))
    else $error("set bit wrong");
  a_swap_mem: assert property (tk && cmd_i.op == OP_NIBBLE_EXCHANGE |=>
    mem_wr_o.we && mem_wr_o.data == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])})
    else $error("swap wrong");
  a_rotl_acc: assert property (tk && cmd_i.op == OP_ROTATE_LEFT_TO_ACC |=>
    !mem_wr_o.we && acc_o == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])} &&
    $stable(flags_o)) else $error("rotate left to acc wrong");
  a_sub_carry: assert property (tk && cmd_i.op == OP_SUBTRACT |=>
    flags_o.carry == ($past(acc_o) >= $past(mem_rdata_i)) && flags_o.zero == (acc_o == 8'h00))
    else $error("subtract flags wrong");
  a_zero_skip: assert property (tk && cmd_i.op == OP_SKIP_IF_ZERO |=>
    skip_o == ($past(mem_rdata_i) == 8'h00) && !mem_wr_o.we && $stable(acc_o))
    else $error("zero test wrong");
  a_bit_skip: assert property (tk && cmd_i.op == OP_SKIP_BIT_NONZERO |=>
    skip_o == $past(mem_rdata_i[cmd_i.bit_sel]) && !mem_wr_o.we) else $error("bit test wrong");
  a_dec_skip: assert property (tk && cmd_i.op == OP_DECREMENT_SKIP_ZERO |=>
    mem_wr_o.we && mem_wr_o.data == $past(mem_rdata_i) - 8'h01 &&
    skip_o == ($past(mem_rdata_i) == 8'h01)) else $error("decrement skip wrong");
  c_borrow: cover property (tk && cmd_i.op == OP_SUBTRACT_WITH_BORROW);
  c_skip: cover property (skip_o);
  c_set_bit: cover property (tk && cmd_i.op == OP_SET_BIT);
  c_move_skip: cover property (tk && cmd_i.op == OP_SKIP_IF_ZERO_MOVE_ACC && mem_rdata_i == 8'h00);
endmodule // rss_datapath_properties

bind rss_datapath rss_datapath_properties u_props (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
  .mem_rdata_i(mem_rdata_i), .cmd_ready_o(cmd_ready_o), .mem_wr_o(mem_wr_o),
  .acc_o(acc_o), .flags_o(flags_o), .skip_o(skip_o), .dummy_o(dummy_o));

// file: tb/rss_mem_model.sv
`timescale 1ns/1ns
// One addressed byte; the address is fixed by the bench acting as sequencer
module rss_mem_model
  import rss_pkg::*;
(
  input  wire logic        clk_sys_i,   // Core clock
  input  wire logic        rst_i,       // Reset
  input  wire logic        load_i,      // Preset byte
  input  wire logic [7:0]  load_data_i, // Preset value
  input  wire rss_mem_wr_t mem_wr_i,    // Write from datapath
  output logic [7:0]       rdata_o      // Byte read
);
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i) rdata_o <= 8'h00;
    else if (load_i) rdata_o <= load_data_i;
    else if (mem_wr_i.we) rdata_o <= mem_wr_i.data;
endmodule // rss_mem_model

// file: tb/testbench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  $display("ERROR %s exp %h got %h", nm, e, g); n_mismatch++; end end
module testbench;
  import rss_pkg::*;
  logic        clk_sys_i, rst_i, cmd_valid, cmd_ready_o, skip_o, dummy_o, load;
  logic [7:0]  load_data, mem_rdata, acc_o, m_acc, m_mem;
  rss_cmd_t    cmd;
  rss_mem_wr_t mem_wr;
  rss_flags_t  flags, m_fl;
  int          n_mismatch, comparisons;
  rss_datapath uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .mem_rdata_i(mem_rdata), .cmd_ready_o(cmd_ready_o), .mem_wr_o(mem_wr), .acc_o(acc_o),
    .flags_o(flags), .skip_o(skip_o), .dummy_o(dummy_o));
  rss_mem_model u_mem (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .load_i(load),
    .load_data_i(load_data), .mem_wr_i(mem_wr), .rdata_o(mem_rdata));
  always #4 clk_sys_i = ~clk_sys_i;
  // ==========================================================================
  // Instruction with reference result
  // ==========================================================================
  task step(input rss_op_t op, input logic [2:0] b, input logic [7:0] x, input logic [7:0] v);
    logic [7:0] r, a, s;
    logic [8:0] d;
    logic [4:0] h;
    logic       we, sk, bi;
    rss_flags_t f, sf;
    int         n;
    @(negedge clk_sys_i) load = 1; load_data = v;
    @(negedge clk_sys_i) load = 0;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 8) begin @(negedge clk_sys_i); n++; end
    s = (op == OP_SUBTRACT_IMM) ? x : v;
    bi = (op == OP_SUBTRACT_WITH_BORROW || op == OP_SUBTRACT_WITH_BORROW_TO_MEM) & ~m_fl.carry;
    d = {1'b0, m_acc} - {1'b0, s} - {8'h00, bi};
    h = {1'b0, m_acc[3:0]} - {1'b0, s[3:0]} - {4'h0, bi};
    sf = '{m_acc[7] != s[7] && d[7] != m_acc[7], d[7:0] == 8'h00, ~h[4], ~d[8]};
    f = m_fl; a = m_acc; r = v; we = 0; sk = 0;
    case (op)
      OP_ROTATE_LEFT: begin r = {v[6:0], v[7]}; we = 1; end
      OP_ROTATE_LEFT_TO_ACC: a = {v[6:0], v[7]};
      OP_ROTATE_LEFT_THROUGH_CARRY: begin r = {v[6:0], m_fl.carry}; we = 1; f.carry = v[7]; end
      OP_ROTATE_LEFT_THROUGH_CARRY_TO_ACC: begin a = {v[6:0], m_fl.carry}; f.carry = v[7]; end
      OP_ROTATE_RIGHT: begin r = {v[0], v[7:1]}; we = 1; end
      OP_ROTATE_RIGHT_TO_ACC: a = {v[0], v[7:1]};
      OP_ROTATE_RIGHT_THROUGH_CARRY: begin r = {m_fl.carry, v[7:1]}; we = 1; f.carry = v[0]; end
      OP_ROTATE_RIGHT_THROUGH_CARRY_TO_ACC: begin a = {m_fl.carry, v[7:1]}; f.carry = v[0]; end
      OP_SUBTRACT, OP_SUBTRACT_IMM, OP_SUBTRACT_WITH_BORROW: begin a = d[7:0]; f = sf; end
      OP_SUBTRACT_TO_MEM, OP_SUBTRACT_WITH_BORROW_TO_MEM: begin r = d[7:0]; we = 1; f = sf; end
      OP_DECREMENT_SKIP_ZERO: begin r = v - 8'h01; we = 1; sk = (r == 8'h00); end
      OP_DECREMENT_SKIP_ZERO_TO_ACC: begin a = v - 8'h01; sk = (a == 8'h00); end
      OP_INCREMENT_SKIP_ZERO: begin r = v + 8'h01; we = 1; sk = (r == 8'h00); end
      OP_INCREMENT_SKIP_ZERO_TO_ACC: begin a = v + 8'h01; sk = (a == 8'h00); end
      OP_SKIP_BIT_NONZERO: sk = v[b];
      OP_SKIP_IF_ZERO: sk = (v == 8'h00);
      OP_SKIP_IF_ZERO_MOVE_ACC: begin a = v; sk = (v == 8'h00); end
      OP_SET_BYTE: begin r = 8'hff; we = 1; end
      OP_SET_BIT: begin r = v | (8'h01 << b); we = 1; end
      OP_NIBBLE_EXCHANGE: begin r = {v[3:0], v[7:4]}; we = 1; end
      OP_NIBBLE_EXCHANGE_TO_ACC: a = {v[3:0], v[7:4]};
      default: ;
    endcase
    cmd_valid = 1; cmd = '{op, b, x};
    @(negedge clk_sys_i) cmd_valid = 0;
    `CHK("acc", a, acc_o)
    `CHK("flags", f, flags)
    `CHK("we", we, mem_wr.we)
    if (we) `CHK("wdata", r, mem_wr.data)
    `CHK("skip", sk, skip_o)
    `CHK("dummy", sk, dummy_o)
    m_acc = a; m_fl = f; m_mem = we ? r : v;
    @(negedge clk_sys_i) `CHK("mem", m_mem, mem_rdata)
    `CHK("ready", 1'b1, cmd_ready_o)
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task t_all_ops;
    for (int i = 1; i <= 24; i++) step(rss_op_t'(5'(i)), 3'(i), 8'h3c, 8'h96 ^ 8'(i * 37));
  endtask
  task t_sub_edges;
    step(OP_SKIP_IF_ZERO_MOVE_ACC, 3'h0, 8'h00, 8'h80);
    step(OP_SUBTRACT, 3'h0, 8'h00, 8'h01);
    step(OP_SUBTRACT_IMM, 3'h0, 8'h7f, 8'h55);
    step(OP_SUBTRACT_WITH_BORROW, 3'h0, 8'h00, 8'h00);
    step(OP_SUBTRACT, 3'h0, 8'h00, 8'h01);
    step(OP_SUBTRACT_WITH_BORROW_TO_MEM, 3'h0, 8'h00, 8'h0f);
    step(OP_SUBTRACT_TO_MEM, 3'h0, 8'h00, 8'hf0);
  endtask
  task t_wraps;
    step(OP_INCREMENT_SKIP_ZERO, 3'h0, 8'h00, 8'hff);
    step(OP_INCREMENT_SKIP_ZERO_TO_ACC, 3'h0, 8'h00, 8'hff);
    step(OP_DECREMENT_SKIP_ZERO, 3'h0, 8'h00, 8'h01);
    step(OP_DECREMENT_SKIP_ZERO_TO_ACC, 3'h0, 8'h00, 8'h01);
    step(OP_DECREMENT_SKIP_ZERO, 3'h0, 8'h00, 8'h00);
    step(OP_SKIP_IF_ZERO_MOVE_ACC, 3'h0, 8'h00, 8'h00);
    step(OP_SKIP_IF_ZERO, 3'h0, 8'h00, 8'h00);
    step(OP_SKIP_BIT_NONZERO, 3'h7, 8'h00, 8'h80);
    step(OP_SKIP_BIT_NONZERO, 3'h0, 8'h00, 8'h80);
    step(OP_ROTATE_RIGHT_THROUGH_CARRY, 3'h0, 8'h00, 8'h01);
    step(OP_ROTATE_LEFT_THROUGH_CARRY_TO_ACC, 3'h0, 8'h00, 8'h00);
  endtask
  // Instruction offered during the dummy cycle must be refused, then taken once ready returns
  task t_refuse;
    @(negedge clk_sys_i) load = 1; load_data = 8'h00;
    @(negedge clk_sys_i) load = 0; cmd_valid = 1; cmd = '{OP_SKIP_IF_ZERO, 3'h0, 8'h00};
    @(negedge clk_sys_i) cmd = '{OP_SET_BYTE, 3'h0, 8'h00};
    `CHK("refuse", 1'b0, cmd_ready_o)
    @(negedge clk_sys_i) `CHK("idle_we", 1'b0, mem_wr.we)
    @(negedge clk_sys_i) cmd_valid = 0;
    `CHK("set_we", 1'b1, mem_wr.we)
    `CHK("set_data", BYTE_ONES, mem_wr.data)
  endtask
  task wrap_up;
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    clk_sys_i = 0; rst_i = 1; cmd_valid = 0; cmd = '0; load = 0; load_data = 8'h00;
    n_mismatch = 0; comparisons = 0; m_acc = 8'h00; m_fl = '0; m_mem = 8'h00;
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i) rst_i = 0;
    t_all_ops();
    t_sub_edges();
    t_wraps();
    t_refuse();
    wrap_up();
  end
endmodule // testbench
